// ### design/psl_buf.sv
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ns
module psl_buf #(
  parameter int unsigned W = 17
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
  } psl_buf_st_t;

  psl_buf_st_t s;
  psl_buf_st_t next_s;
  logic push;
  logic pop;

  // Handshake terms
  assign o_in_ready = (s.cnt != 2'h2);
  assign o_out_valid = (s.cnt != 2'h0);
  assign o_out_data = s.head;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Entry and count update
  always_comb
  begin
    next_s = s;
    if (push && pop)
    begin
      if (s.cnt == 2'h1)
        next_s.head = i_in_data;
      else
      begin
        next_s.head = s.tail;
        next_s.tail = i_in_data;
      end
    end
    else if (pop)
    begin
      next_s.head = s.tail;
      next_s.cnt = s.cnt - 2'h1;
    end
    else if (push)
    begin
      if (s.cnt == 2'h0)
        next_s.head = i_in_data;
      else
        next_s.tail = i_in_data;
      next_s.cnt = s.cnt + 2'h1;
    end
  end

  // State register
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      s <= '0;
    else
      s <= next_s;
  end

endmodule // psl_buf

// ### design/psl_pkg.sv
// Shared constants, types and helpers of the pressure sensor link port
package psl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BAUD = 38_400;
  localparam logic [11:0] BIT_CYCLES = 12'(CLK_HZ / BAUD);
  localparam logic [11:0] HALF_BIT_CYCLES = 12'(CLK_HZ / BAUD / 2);
  localparam int unsigned WAKE_NS = 75_000;
  localparam int unsigned WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FALLBACK_MS = 50;
  localparam int unsigned FALLBACK_CYCLES = FALLBACK_MS * (CLK_HZ / 1000);

  // ****************************************
  // Frame and word layout
  // ****************************************
  localparam int unsigned PD_WIDTH = 16;
  localparam int unsigned MEAS_WIDTH = 14;
  localparam int unsigned MEAS_LSB = 2;
  localparam int unsigned SWITCH_BIT = 0;
  localparam int unsigned CMD_PD_BIT = 7;
  localparam logic [13:0] MEAS_MAX = 14'h3fff;
  localparam logic [3:0] LAST_BIT_IDX = 4'h9;

  // ****************************************
  // Parameter access answers
  // ****************************************
  localparam logic [15:0] ANS_OK = 16'h0000;
  localparam logic [15:0] ERR_NO_INDEX = 16'h8011;
  localparam logic [15:0] ERR_NO_SUBINDEX = 16'h8012;
  localparam logic [15:0] ERR_DENIED = 16'h8023;
  localparam logic [15:0] ERR_RANGE = 16'h8030;
  localparam logic [15:0] ERR_OVERRUN = 16'h8033;
  localparam logic [15:0] ERR_UNDERRUN = 16'h8034;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PERR_NONE = 3'h0,
    PERR_NO_INDEX = 3'h1,
    PERR_NO_SUBINDEX = 3'h2,
    PERR_DENIED = 3'h3,
    PERR_RANGE = 3'h4,
    PERR_OVERRUN = 3'h5,
    PERR_UNDERRUN = 3'h6
  } psl_perr_t;

  typedef enum logic [2:0] {
    ST_SIO = 3'b001,
    ST_LISTEN = 3'b010,
    ST_TX = 3'b100
  } psl_mode_t;

  typedef struct packed {
    logic switching_state_bit;
    logic [15:0] raw;
  } psl_sample_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] gain;
  } psl_range_t;

  // ****************************************
  // Helpers
  // ****************************************
  // Clamp to range, offset, apply gain and saturate to fourteen bits
  function automatic logic [13:0] psl_scale(input logic [15:0] raw, input psl_range_t rng);
    logic [15:0] clip;
    logic [31:0] prod;
    clip = raw;
    if (raw < rng.lo)
      clip = rng.lo;
    if (raw > rng.hi)
      clip = rng.hi;
    prod = 32'(clip - rng.lo) * 32'(rng.gain);
    if (prod[31:16] > 16'(MEAS_MAX))
      return MEAS_MAX;
    return prod[29:16];
  endfunction

  // Answer word for a parameter access
  function automatic logic [15:0] psl_answer(input psl_perr_t code);
    unique case (code)
      PERR_NO_INDEX: return ERR_NO_INDEX;
      PERR_NO_SUBINDEX: return ERR_NO_SUBINDEX;
      PERR_DENIED: return ERR_DENIED;
      PERR_RANGE: return ERR_RANGE;
      PERR_OVERRUN: return ERR_OVERRUN;
      PERR_UNDERRUN: return ERR_UNDERRUN;
      default: return ANS_OK;
    endcase
  endfunction

  // Line character, LSB first: start, eight data, even parity, stop
  function automatic logic [10:0] psl_char(input logic [7:0] b);
    return {1'b1, ^b, b, 1'b0};
  endfunction

endpackage

// ### design/psl_port.sv
// Device end of the single-wire sensor link: standard IO and communication mode
`timescale 1ns/1ns
module psl_port #(
  parameter int unsigned WAKE_CYCLES = psl_pkg::WAKE_CYCLES,
  parameter int unsigned FALLBACK_CYCLES = psl_pkg::FALLBACK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_cq_in,
  output logic o_cq_out,
  output logic o_cq_oe,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire psl_pkg::psl_sample_t i_sample,
  input wire psl_pkg::psl_range_t i_range,
  output logic o_param_req,
  output logic [6:0] o_param_index,
  input wire psl_pkg::psl_perr_t i_param_code,
  output logic o_frame_err,
  output logic o_comm_mode,
  output logic [15:0] o_pd_word
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    psl_pkg::psl_mode_t mode;
    logic [2:0] sync;
    logic line;
    logic [15:0] wake_cnt;
    logic [23:0] idle_cnt;
    logic rx_busy;
    logic [11:0] bit_cnt;
    logic [3:0] bit_idx;
    logic [9:0] rx_sh;
    logic [10:0] tx_sh;
    logic second;
    logic [7:0] tx_low;
    logic [15:0] pd;
    logic param_req;
    logic [6:0] param_index;
    logic frame_err;
    logic cq_out;
    logic cq_oe;
  } psl_port_st_t;

  localparam psl_port_st_t RST = '{
    mode: psl_pkg::ST_SIO, sync: 3'h7, line: 1'b1, wake_cnt: 16'h0000,
    idle_cnt: 24'h000000, rx_busy: 1'b0, bit_cnt: 12'h000, bit_idx: 4'h0,
    rx_sh: 10'h3ff, tx_sh: 11'h7ff, second: 1'b0, tx_low: 8'h00, pd: 16'h0000,
    param_req: 1'b0, param_index: 7'h00, frame_err: 1'b0, cq_out: 1'b0, cq_oe: 1'b1
  };

  psl_port_st_t s;
  psl_port_st_t next_s;
  logic buf_valid;
  logic buf_ready;
  psl_pkg::psl_sample_t buf_data;

  // ****************************************
  // Sample buffer
  // ****************************************
  psl_buf #(
    .W($bits(psl_pkg::psl_sample_t))
  ) u_buf (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_in_valid(i_sample_valid),
    .o_in_ready(o_sample_ready),
    .i_in_data(i_sample),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_ready),
    .o_out_data(buf_data)
  );

  // Word stays still while it is on the line
  assign buf_ready = (s.mode != psl_pkg::ST_TX);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [9:0] rx_next;
    logic [15:0] word;
    logic load_tx;
    rx_next = {s.line, s.rx_sh[9:1]};
    word = psl_pkg::ANS_OK;
    load_tx = 1'b0;
    next_s = s;
    next_s.param_req = 1'b0;
    next_s.frame_err = 1'b0;

    // Three-stage pin sync, level taken when stages two and three agree
    next_s.sync = {s.sync[1:0], i_cq_in};
    if (s.sync[1] == s.sync[2])
      next_s.line = s.sync[2];

    // Measurement and switch bit enter the word in one step
    if (buf_valid && buf_ready)
    begin
      next_s.pd = {psl_pkg::psl_scale(buf_data.raw, i_range), 1'b0,
                   buf_data.switching_state_bit};
    end

    unique case (s.mode)
      psl_pkg::ST_SIO:
      begin
        // Master pulling against our output for the wake time
        if (s.line != s.cq_out)
          next_s.wake_cnt = s.wake_cnt + 16'h0001;
        else
          next_s.wake_cnt = 16'h0000;
        if (s.wake_cnt >= 16'(WAKE_CYCLES - 1))
        begin
          next_s.mode = psl_pkg::ST_LISTEN;
          next_s.wake_cnt = 16'h0000;
          next_s.idle_cnt = 24'h000000;
          next_s.rx_busy = 1'b0;
        end
      end
      psl_pkg::ST_LISTEN:
      begin
        next_s.idle_cnt = s.idle_cnt + 24'h000001;
        if (s.param_req)
        begin
          word = psl_pkg::psl_answer(i_param_code);
          load_tx = 1'b1;
        end
        else if (!s.rx_busy)
        begin
          if (!s.line)
          begin
            next_s.rx_busy = 1'b1;
            next_s.bit_cnt = psl_pkg::HALF_BIT_CYCLES;
            next_s.bit_idx = 4'h0;
          end
          else if (s.idle_cnt >= 24'(FALLBACK_CYCLES - 1))
            next_s.mode = psl_pkg::ST_SIO;
        end
        else if (s.bit_cnt != 12'h000)
          next_s.bit_cnt = s.bit_cnt - 12'h001;
        else
        begin
          next_s.bit_cnt = psl_pkg::BIT_CYCLES - 12'h001;
          if (s.bit_idx == 4'h0)
          begin
            next_s.bit_idx = 4'h1;
            if (s.line)
              next_s.rx_busy = 1'b0;
          end
          else
          begin
            next_s.rx_sh = rx_next;
            next_s.bit_idx = s.bit_idx + 4'h1;
            if (s.bit_idx == psl_pkg::LAST_BIT_IDX + 4'h1)
            begin
              next_s.rx_busy = 1'b0;
              if (rx_next[9] && !(^rx_next[8:0]))
              begin
                next_s.idle_cnt = 24'h000000;
                if (rx_next[psl_pkg::CMD_PD_BIT])
                begin
                  word = s.pd;
                  load_tx = 1'b1;
                end
                else
                begin
                  next_s.param_req = 1'b1;
                  next_s.param_index = rx_next[6:0];
                end
              end
              else
                next_s.frame_err = 1'b1;
            end
          end
        end
      end
      psl_pkg::ST_TX:
      begin
        if (s.bit_cnt != 12'h000)
          next_s.bit_cnt = s.bit_cnt - 12'h001;
        else
        begin
          next_s.bit_cnt = psl_pkg::BIT_CYCLES - 12'h001;
          next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
          next_s.bit_idx = s.bit_idx + 4'h1;
          if (s.bit_idx == psl_pkg::LAST_BIT_IDX + 4'h1)
          begin
            next_s.bit_idx = 4'h0;
            if (s.second)
            begin
              next_s.tx_sh = psl_pkg::psl_char(s.tx_low);
              next_s.second = 1'b0;
            end
            else
            begin
              next_s.mode = psl_pkg::ST_LISTEN;
              next_s.idle_cnt = 24'h000000;
            end
          end
        end
      end
      default:
        next_s.mode = psl_pkg::ST_SIO;
    endcase

    // Start a two-character answer, high byte first
    if (load_tx)
    begin
      next_s.mode = psl_pkg::ST_TX;
      next_s.tx_sh = psl_pkg::psl_char(word[15:8]);
      next_s.tx_low = word[7:0];
      next_s.second = 1'b1;
      next_s.bit_idx = 4'h0;
      next_s.bit_cnt = psl_pkg::BIT_CYCLES - 12'h001;
    end

    // One line drives both roles
    unique case (next_s.mode)
      psl_pkg::ST_SIO:
      begin
        next_s.cq_oe = 1'b1;
        next_s.cq_out = next_s.pd[psl_pkg::SWITCH_BIT];
      end
      psl_pkg::ST_TX:
      begin
        next_s.cq_oe = 1'b1;
        next_s.cq_out = next_s.tx_sh[0];
      end
      default:
      begin
        next_s.cq_oe = 1'b0;
        next_s.cq_out = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Registers and outputs
  // ****************************************
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      s <= RST;
    else
      s <= next_s;
  end

  assign o_cq_out = s.cq_out;
  assign o_cq_oe = s.cq_oe;
  assign o_param_req = s.param_req;
  assign o_param_index = s.param_index;
  assign o_frame_err = s.frame_err;
  assign o_comm_mode = (s.mode != psl_pkg::ST_SIO);
  assign o_pd_word = s.pd;

endmodule // psl_port

// ### test/psl_master_model.sv
// Master side model of the single-wire link
`timescale 1ns/1ns
module psl_master_model (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_drive,
  output logic o_level
);
  // Released at start
  initial
  begin
    o_drive = 1'b0;
    o_level = 1'b1;
  end
  // Hold the line against the device
  task automatic oppose(input int n);
    @(posedge i_clock);
    o_level <= ~i_line;
    o_drive <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_drive <= 1'b0;
  endtask
  // One 8E1 char, stop cut to half so the answer is not blocked
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] ch;
    ch = {1'b1, ^b, b, 1'b0};
    @(posedge i_clock);
    o_drive <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      o_level <= ch[i];
      repeat (i == 10 ? psl_pkg::HALF_BIT_CYCLES : psl_pkg::BIT_CYCLES) @(posedge i_clock);
    end
    o_drive <= 1'b0;
  endtask
  // Receive one char sampled mid bit
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    logic [9:0] s;
    int t;
    t = 0;
    while (i_line !== 1'b0 && t < 8000)
    begin
      @(posedge i_clock);
      t++;
    end
    repeat (psl_pkg::HALF_BIT_CYCLES) @(posedge i_clock);
    for (int i = 0; i < 10; i++)
    begin
      repeat (psl_pkg::BIT_CYCLES) @(posedge i_clock);
      s[i] = i_line;
    end
    b = s[7:0];
    ok = (t < 8000) && !(^s[8:0]) && s[9];
  endtask
endmodule // psl_master_model

// ### test/psl_port_sva.sv
// Port checks of the sensor link port
`timescale 1ns/1ns
module psl_port_sva #(
  parameter int unsigned WAKE_CYCLES = 20,
  parameter int unsigned FALLBACK_CYCLES = 200000
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_cq_in,
  input wire logic o_cq_out,
  input wire logic o_cq_oe,
  input wire logic o_sample_ready,
  input wire logic o_param_req,
  input wire logic o_comm_mode,
  input wire logic [15:0] o_pd_word
);
  localparam int TX_MIN = 22 * 2604 - 1;
  localparam int TX_MAX = 22 * 2604 + 1;
  int opp_cnt;
  int tx_cnt;
  // ****
  // Helpers
  // ****
  // Opposed line time and answer length
  always_ff @(posedge i_clock)
  begin
    opp_cnt <= (i_reset || o_comm_mode || i_cq_in == o_cq_out) ? 0 : opp_cnt + 1;
    tx_cnt <= (i_reset || !o_comm_mode || !o_cq_oe) ? 0 : tx_cnt + 1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ****
  // Assertions
  // ****
  spare_bit_a: assert property (o_pd_word[1] == 1'b0)
    else $error("pd bit 1 set");
  sio_drive_a: assert property (
    !o_comm_mode && !$past(o_comm_mode) |-> o_cq_oe && o_cq_out == o_pd_word[0])
    else $error("sio line wrong");
  wake_len_a: assert property ($rose(o_comm_mode) |-> opp_cnt >= WAKE_CYCLES)
    else $error("wake too short");
  param_ans_a: assert property (o_param_req |-> ##[1:2] (o_cq_oe && !o_cq_out))
    else $error("no answer start");
  tx_len_a: assert property (
    $fell(o_cq_oe) && $past(o_comm_mode) |-> tx_cnt >= TX_MIN && tx_cnt <= TX_MAX)
    else $error("answer length wrong");
  start_bit_a: assert property ($rose(o_cq_oe) && o_comm_mode |-> (!o_cq_out) [*8])
    else $error("no start bit");
  sio_ready_a: assert property (
    !o_comm_mode && !$past(o_comm_mode) |-> o_sample_ready)
    else $error("stall in sio");
  pd_frozen_a: assert property (
    o_comm_mode && o_cq_oe && $past(o_cq_oe) |-> $stable(o_pd_word))
    else $error("pd changed in answer");
endmodule // psl_port_sva

// ### test/psl_port_tb.sv
// Testbench of the sensor link port
`timescale 1ns/1ns
module psl_port_tb;
  localparam logic [15:0] LO = 16'h1000;
  localparam logic [15:0] HI = 16'h9000;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic valid = 1'b0;
  psl_pkg::psl_sample_t smp = '0;
  psl_pkg::psl_range_t rng = '{LO, HI, 16'h7ffe};
  psl_pkg::psl_perr_t code = psl_pkg::PERR_NONE;
  logic line, m_drive, m_level, ready, preq, ferr, comm, oe, cq, r, ok0, ok1;
  logic [6:0] pidx;
  logic [15:0] pd, w, exp_pd;
  logic [7:0] b0, b1;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int taken;
  // ****
  // Line, device and master
  // ****
  // Master wins, pull-up holds a free line high
  assign line = m_drive ? m_level : (oe ? cq : 1'b1);
  psl_port #(.WAKE_CYCLES(20), .FALLBACK_CYCLES(200000)) u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_cq_in(line), .o_cq_out(cq), .o_cq_oe(oe),
    .i_sample_valid(valid), .o_sample_ready(ready), .i_sample(smp), .i_range(rng),
    .o_param_req(preq), .o_param_index(pidx), .i_param_code(code), .o_frame_err(ferr),
    .o_comm_mode(comm), .o_pd_word(pd));
  psl_master_model u_master (.i_clock(i_clock), .i_line(line), .o_drive(m_drive),
    .o_level(m_level));
  // Clock and hang limit
  initial forever #5 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 120000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  // ****
  // Helpers
  // ****
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clamp, offset, gain, saturate
  function automatic logic [15:0] exp_word(input psl_pkg::psl_sample_t s);
    logic [15:0] c;
    logic [31:0] p;
    c = s.raw < LO ? LO : (s.raw > HI ? HI : s.raw);
    p = 32'(c - LO) * 32'h7ffe;
    return {(p[31:16] > 16'h3fff) ? 14'h3fff : p[29:16], 1'b0, s.switching_state_bit};
  endfunction
  function automatic psl_pkg::psl_sample_t rnd();
    return psl_pkg::psl_sample_t'(17'($urandom));
  endfunction
  task automatic push(input psl_pkg::psl_sample_t s);
    @(posedge i_clock);
    valid <= 1'b1;
    smp <= s;
    @(posedge i_clock);
    valid <= 1'b0;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    psl_pkg::psl_sample_t s;
    void'($urandom(30264));
    repeat (20) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    check("reset", {comm, oe, ready, pd[12:0]}, 16'h6000);
    for (int i = 0; i < 8; i++)
    begin
      s = rnd();
      s.raw = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : s.raw;
      push(s);
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      check("pd word", pd, exp_word(s));
      check("sio line", 16'({oe, cq}), 16'({1'b1, s.switching_state_bit}));
    end
    u_master.oppose(15);
    repeat (10) @(negedge i_clock);
    check("short wake", 16'(comm), 16'h0000);
    u_master.oppose(28);
    @(negedge i_clock);
    check("comm entry", 16'({comm, oe}), 16'h0002);
    for (int i = 0; i < 3; i++)
    begin
      s = rnd();
      push(s);
    end
    repeat (20) @(posedge i_clock);
    exp_pd = exp_word(s);
    check("listen drain", pd, exp_pd);
    taken = 0;
    u_master.send_byte(8'h80);
    fork
      begin
        u_master.recv_byte(b0, ok0);
        u_master.recv_byte(b1, ok1);
      end
      begin
        repeat (20) @(posedge i_clock);
        s = rnd();
        valid <= 1'b1;
        smp <= s;
        repeat (6)
        begin
          @(negedge i_clock);
          r = ready;
          @(posedge i_clock);
          if (r)
          begin
            taken++;
            w = exp_word(s);
            s = rnd();
            smp <= s;
          end
        end
        valid <= 1'b0;
        @(negedge i_clock);
        check("full", {15'(taken), ready}, 16'h0004);
      end
    join
    check("pd on line", {b0, b1}, exp_pd);
    check("char frame", 16'({ok0, ok1}), 16'h0003);
    // Answer still owns the line for the rest of its stop bit
    repeat (1400) @(negedge i_clock);
    check("fifo drain", pd, w);
    @(posedge i_clock);
    code <= psl_pkg::psl_perr_t'(3'($urandom_range(6)));
    b0 = {1'b0, 7'($urandom)};
    fork
      u_master.send_byte(b0);
      begin
        taken = 0;
        while (preq !== 1'b1 && taken < 40000)
        begin
          @(negedge i_clock);
          taken++;
        end
        check("param index", 16'(pidx), 16'(b0[6:0]));
      end
    join
    repeat (5) @(posedge i_clock);
    finish_test();
  end
endmodule // psl_port_tb
bind psl_port psl_port_sva #(.WAKE_CYCLES(WAKE_CYCLES), .FALLBACK_CYCLES(FALLBACK_CYCLES)) u_sva (
  .i_clock(i_clock), .i_reset(i_reset), .i_cq_in(i_cq_in), .o_cq_out(o_cq_out),
  .o_cq_oe(o_cq_oe), .o_sample_ready(o_sample_ready), .o_param_req(o_param_req),
  .o_comm_mode(o_comm_mode), .o_pd_word(o_pd_word));
